// [rtl/crc_top.sv]
// Clock ratio, reduced power and power-on reset control with APB registers.
`timescale 1ns/1ps
module crc_top (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic warm_reset_n,
    input wire logic [1:0] clock_ratio_select_pins,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic pipeline_clock,
    output logic system_interface_clock,
    output logic transmit_clock,
    output logic pipeline_reset,
    output logic system_reset,
    output logic endian_select,
    output logic write_slot
);
    crc_div_if pipe_if ();
    crc_div_if sys_if ();

    logic rs1_q;
    logic rs2_q;
    logic warm1_q;
    logic warm2_q;
    logic [1:0] pin1_q;
    logic [1:0] pin2_q;
    logic core_rst_q;
    logic lowpwr_cfg_q;
    logic lowpwr_act_q;
    crc_pkg::crc_ratio_t ratio_act_q;
    logic endian_q;
    logic pattern_q;
    logic [4:0] frame_q;
    logic odd_q;
    logic [1:0] slot_q;
    logic write_slot_q;
    logic [31:0] prdata_q;

    logic [4:0] frame_len;
    logic frame_end;
    logic pair_end;
    logic sel_cfg;
    logic sel_stat;
    logic sel_any;
    logic setup;
    logic wr_take;
    logic [31:0] cfg_word;
    logic [31:0] stat_word;
    logic [31:0] rd_word;
    logic slot_ok;

    // R7 async reset sync
    // Assertion acts at once; release passes two flops first.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rs1_q <= 1'b0;
            rs2_q <= 1'b0;
        end else begin
            rs1_q <= 1'b1;
            rs2_q <= rs1_q;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            warm1_q <= 1'b0;
            warm2_q <= 1'b0;
            pin1_q <= 2'h0;
            pin2_q <= 2'h0;
        end else begin
            warm1_q <= warm_reset_n;
            warm2_q <= warm1_q;
            pin1_q <= clock_ratio_select_pins;
            pin2_q <= pin1_q;
        end
    end

    // R3 quarter rate frame
    assign frame_len = crc_pkg::crc_sys_period(lowpwr_act_q);
    assign frame_end = (frame_q == frame_len - 5'h1);
    // A 1.5x period does not divide one frame, only a pair of frames.
    assign pair_end = frame_end && !odd_q;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            frame_q <= 5'h0;
            odd_q <= 1'b0;
        end else if (frame_end) begin
            frame_q <= 5'h0;
            odd_q <= !odd_q;
        end else begin
            frame_q <= frame_q + 5'h1;
        end
    end

    // R13 switch at boundary
    // Every derived period divides a pair of frames, so the end of a pair
    // is a moment when all clocks sit at a common edge, for every ratio.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lowpwr_act_q <= crc_pkg::LOWPWR_RST;
            ratio_act_q <= crc_pkg::CRC_RATIO_1X;
        end else if (pair_end) begin
            lowpwr_act_q <= lowpwr_cfg_q;
            ratio_act_q <= crc_pkg::crc_ratio_t'(pin2_q);
        end
    end

    // R12 one synchronised release for both domains
    // R8 warm reset optional
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            core_rst_q <= 1'b1;
        end else if (!rs2_q || !warm2_q) begin
            core_rst_q <= 1'b1;
        end else if (frame_end) begin
            core_rst_q <= 1'b0;
        end
    end

    // R1 pipeline ratio select
    assign pipe_if.period = crc_pkg::crc_pipe_period(ratio_act_q,
        lowpwr_act_q);
    assign pipe_if.high = crc_pkg::crc_high(pipe_if.period);
    assign pipe_if.start = pair_end;
    assign pipe_if.run = rs2_q;

    // R2 system at reference rate
    assign sys_if.period = frame_len;
    assign sys_if.high = crc_pkg::crc_high(frame_len);
    assign sys_if.start = frame_end;
    assign sys_if.run = rs2_q;

    crc_clkgen u_pipe (
        .ref_clk(ref_clk),
        .rst(rst),
        .div(pipe_if.gen)
    );

    crc_clkgen u_sys (
        .ref_clk(ref_clk),
        .rst(rst),
        .div(sys_if.gen)
    );

    // R9 no extra clock outputs
    // Only the three derived clocks leave the block.
    assign pipeline_clock = pipe_if.clk_lvl;
    assign system_interface_clock = sys_if.clk_lvl;
    assign transmit_clock = sys_if.clk_lvl;
    assign pipeline_reset = core_rst_q;
    assign system_reset = core_rst_q;
    assign endian_select = endian_q;
    assign write_slot = write_slot_q;

    assign setup = psel && !penable;
    assign sel_cfg = (paddr == crc_pkg::CFG_OFFSET);
    assign sel_stat = (paddr == crc_pkg::STAT_OFFSET);
    assign sel_any = sel_cfg || sel_stat;
    assign wr_take = psel && penable && pwrite && sel_cfg;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !sel_any;
    assign prdata = prdata_q;

    // R5 fixed bits read 01
    always_comb begin
        cfg_word = 32'h0;
        cfg_word[crc_pkg::CFG_LOWPWR_BIT] = lowpwr_cfg_q;
        cfg_word[crc_pkg::CFG_ENDIAN_BIT] = endian_q;
        cfg_word[crc_pkg::CFG_FIXED_LSB +: 2] = crc_pkg::CFG_FIXED_VAL;
        cfg_word[crc_pkg::CFG_PATTERN_BIT] = pattern_q;
    end

    always_comb begin
        stat_word = 32'h0;
        stat_word[crc_pkg::STAT_RATIO_LSB +: 2] = ratio_act_q;
        stat_word[crc_pkg::STAT_LOWPWR_BIT] = lowpwr_act_q;
        stat_word[crc_pkg::STAT_RST_BIT] = core_rst_q;
        stat_word[crc_pkg::STAT_PINS_LSB +: 2] = pin2_q;
    end

    assign rd_word = sel_cfg ? cfg_word : (sel_stat ? stat_word : 32'h0);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prdata_q <= 32'h0;
        end else if (setup) begin
            prdata_q <= rd_word;
        end
    end

    // R4 defaults on power-on only
    // Warm reset leaves these fields alone; only rst reloads them.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lowpwr_cfg_q <= crc_pkg::LOWPWR_RST;
            endian_q <= crc_pkg::ENDIAN_RST;
            pattern_q <= crc_pkg::PATTERN_RST;
        end else if (wr_take) begin
            lowpwr_cfg_q <= pwdata[crc_pkg::CFG_LOWPWR_BIT];
            endian_q <= pwdata[crc_pkg::CFG_ENDIAN_BIT];
            pattern_q <= pwdata[crc_pkg::CFG_PATTERN_BIT];
        end
    end

    // R6 programmable write rate
    // R10 sparse write pattern
    assign slot_ok = (pattern_q == crc_pkg::PATTERN_D) || (slot_q == 2'h0);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            slot_q <= 2'h0;
            write_slot_q <= 1'b0;
        end else begin
            write_slot_q <= sys_if.rise && slot_ok && !core_rst_q;
            if (core_rst_q) begin
                slot_q <= 2'h0;
            end else if (sys_if.rise) begin
                slot_q <= (slot_q == crc_pkg::DXX_STRIDE - 2'h1) ? 2'h0
                          : slot_q + 2'h1;
            end
        end
    end

    // Helper counters measure the gap between rising edges of each clock.
    logic [5:0] pgap_q;
    logic [4:0] pexp_q;
    logic pok_q;
    logic [5:0] sgap_q;
    logic [4:0] sexp_q;
    logic sok_q;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pgap_q <= 6'h0;
            pexp_q <= 5'h0;
            pok_q <= 1'b0;
            sgap_q <= 6'h0;
            sexp_q <= 5'h0;
            sok_q <= 1'b0;
        end else begin
            pgap_q <= pipe_if.rise ? 6'h1 : pgap_q + 6'h1;
            sgap_q <= sys_if.rise ? 6'h1 : sgap_q + 6'h1;
            if (pipe_if.rise) begin
                pexp_q <= pipe_if.period;
                pok_q <= 1'b1;
            end
            if (sys_if.rise) begin
                sexp_q <= sys_if.period;
                sok_q <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_pipe_period_gap: assert property ( // R1
        pipe_if.rise && pok_q && pipe_if.period == pexp_q
        |-> pgap_q == {1'b0, pexp_q})
        else $error("pipeline clock period wrong");

    a_sys_period_gap: assert property ( // R2
        sys_if.rise && sok_q && sys_if.period == sexp_q
        |-> sgap_q == {1'b0, sexp_q}
        && (pipe_if.rise || ratio_act_q == crc_pkg::CRC_RATIO_1P5X))
        else $error("system clock period wrong");

    a_lowpwr_quarter: assert property ( // R3
        lowpwr_act_q |-> sys_if.period
        == 5'(crc_pkg::BASE_TICKS * crc_pkg::LOWPWR_FACTOR)
        && pipe_if.period == crc_pkg::crc_pipe_period(ratio_act_q, 1'b0)
        * crc_pkg::LOWPWR_FACTOR)
        else $error("reduced power rate not a quarter");

    a_cfg_write_stick: assert property ( // R4
        wr_take |=> endian_q == $past(pwdata[crc_pkg::CFG_ENDIAN_BIT])
        && pattern_q == $past(pwdata[crc_pkg::CFG_PATTERN_BIT]))
        else $error("config write not stored");

    a_fixed_bits_read: assert property ( // R5
        psel && penable && !pwrite && sel_cfg |-> prdata[19:18] == 2'h1)
        else $error("config bits 19:18 not 01");

    a_fast_rate_slots: assert property ( // R6
        write_slot && pattern_q == crc_pkg::PATTERN_D && !lowpwr_act_q
        |-> ##6 (write_slot || pattern_q != crc_pkg::PATTERN_D
                 || lowpwr_act_q || core_rst_q))
        else $error("fast rate missed a slot");

    a_sparse_idle_gap: assert property ( // R10
        write_slot && pattern_q == crc_pkg::PATTERN_DXX
        |=> !write_slot [*8])
        else $error("sparse rate slots too close");

    a_reset_hold_sync: assert property ( // R7
        !rs2_q |=> core_rst_q)
        else $error("domain left reset before sync");

    a_release_boundary: assert property ( // R12
        $fell(core_rst_q) |-> $past(frame_end) && $past(rs2_q))
        else $error("reset release off boundary");

    a_no_warm_needed: assert property ( // R8
        $rose(rs2_q) ##1 warm2_q |-> ##[1:30] (!core_rst_q || !warm2_q))
        else $error("reset did not complete without warm reset");

    a_switch_boundary: assert property ( // R13
        !$stable(lowpwr_act_q) || !$stable(ratio_act_q) |-> $past(pair_end))
        else $error("clock change off boundary");

    c_lowpwr_entered: cover property ($rose(lowpwr_act_q));
    c_ratio_1p5x: cover property (
        pipe_if.rise && ratio_act_q == crc_pkg::CRC_RATIO_1P5X);
    c_sparse_slot: cover property (
        write_slot && pattern_q == crc_pkg::PATTERN_DXX);
    c_reset_done: cover property ($fell(core_rst_q));
endmodule

// [rtl/crc_pkg.sv]
// Constants, types and helpers shared by the clock ratio and reset block.
// Notes on behaviour
// R1: The pipeline clock is the reference rate times 1x, 2x, 3x or 1.5x, picked by the two ratio select pins.
// R2: The system interface and transmit clocks run at the reference rate, independent of the pipeline clock.
// R3: With the reduced power bit set all three clocks run at a quarter of their normal rate.
// R4: Endian select and write data pattern take their defaults only at power-on reset and stay writable.
// R5: Configuration bits [19:18] always read as 01.
// R6: The write data rate comes from a configuration setting whose fastest choice gives one word per cycle.
// R7: Power-on reset may be asserted and released at any moment, unaligned to any clock.
// R8: Power-on reset completes even if warm reset is never asserted.
// R9: No reference clock output and no receive clock output exist.
// R10: Two write data rates exist, every cycle or one word followed by two idle cycles, set by the pattern field.
// R11: Outside logic timed from the interface clock must let software adapt to the quartered rate.
// R12: Release of power-on reset is synchronised before the clocked domains leave reset.
// R13: Ratio and reduced power changes take effect only at a common clock boundary.
package crc_pkg;

    // Ticks of ref_clk in one period of the derived reference rate.
    localparam int unsigned BASE_TICKS = 6;
    localparam int unsigned LOWPWR_FACTOR = 4;

    localparam logic [11:0] CFG_OFFSET = 12'h000;
    localparam logic [11:0] STAT_OFFSET = 12'h004;

    localparam int unsigned CFG_LOWPWR_BIT = 0;
    localparam int unsigned CFG_ENDIAN_BIT = 15;
    localparam int unsigned CFG_FIXED_LSB = 18;
    localparam int unsigned CFG_PATTERN_BIT = 24;
    localparam logic [1:0] CFG_FIXED_VAL = 2'h1;

    localparam int unsigned STAT_RATIO_LSB = 0;
    localparam int unsigned STAT_LOWPWR_BIT = 2;
    localparam int unsigned STAT_RST_BIT = 3;
    localparam int unsigned STAT_PINS_LSB = 4;

    localparam logic LOWPWR_RST = 1'b0;
    localparam logic ENDIAN_RST = 1'b0;
    localparam logic PATTERN_D = 1'b0;
    localparam logic PATTERN_DXX = 1'b1;
    localparam logic PATTERN_RST = PATTERN_DXX;
    // System clock cycles per data word in the sparse pattern.
    localparam logic [1:0] DXX_STRIDE = 2'h3;

    typedef enum logic [1:0] {
        CRC_RATIO_1X = 2'b00,
        CRC_RATIO_2X = 2'b01,
        CRC_RATIO_3X = 2'b10,
        CRC_RATIO_1P5X = 2'b11
    } crc_ratio_t;

    function automatic logic [4:0] crc_pipe_period(crc_ratio_t r,
        logic slow);
        int unsigned p;
        p = BASE_TICKS;
        case (r)
            CRC_RATIO_2X: p = BASE_TICKS / 2;
            CRC_RATIO_3X: p = BASE_TICKS / 3;
            CRC_RATIO_1P5X: p = (BASE_TICKS * 2) / 3;
            default: p = BASE_TICKS;
        endcase
        if (slow) begin
            p = p * LOWPWR_FACTOR;
        end
        return p[4:0];
    endfunction

    function automatic logic [4:0] crc_sys_period(logic slow);
        int unsigned p;
        p = slow ? BASE_TICKS * LOWPWR_FACTOR : BASE_TICKS;
        return p[4:0];
    endfunction

    function automatic logic [4:0] crc_high(logic [4:0] period);
        logic [5:0] h;
        h = ({1'b0, period} + 6'h1) >> 1;
        return h[4:0];
    endfunction

endpackage

// [rtl/crc_div_if.sv]
// Link between the controller and one clock divider.
`timescale 1ns/1ps
interface crc_div_if;
    logic [4:0] period;
    logic [4:0] high;
    logic start;
    logic run;
    logic clk_lvl;
    logic rise;

    modport gen (
        input period,
        input high,
        input start,
        input run,
        output clk_lvl,
        output rise
    );

    modport ctl (
        output period,
        output high,
        output start,
        output run,
        input clk_lvl,
        input rise
    );
endinterface

// [rtl/crc_clkgen.sv]
// Divider that turns ref_clk into one derived clock level.
`timescale 1ns/1ps
module crc_clkgen (
    input wire logic ref_clk,
    input wire logic rst,
    crc_div_if.gen div
);
    logic [4:0] cnt_q;
    logic [4:0] cnt_d;
    logic clk_q;
    logic rise_q;
    logic wrap;

    // A frame start realigns the count so a new period never cuts a pulse.
    assign wrap = div.start || (cnt_q == div.period - 5'h1);
    assign cnt_d = (!div.run || wrap) ? 5'h0 : cnt_q + 5'h1;
    assign div.clk_lvl = clk_q;
    assign div.rise = rise_q;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 5'h0;
            clk_q <= 1'b0;
            rise_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            clk_q <= div.run && (cnt_d < div.high);
            rise_q <= div.run && (cnt_d == 5'h0);
        end
    end
endmodule

// [sim/crc_board_model.sv]
// Board model: reset circuit, ratio strap pins and a refresh agent.
`timescale 1ns/1ps
module crc_board_model (
    input wire logic ref_clk,
    input wire logic system_interface_clock,
    output logic rst,
    output logic warm_reset_n,
    output logic [1:0] clock_ratio_select_pins
);
    int refresh_cnt;
    initial begin
        rst = 1'b1;
        warm_reset_n = 1'b1;
        clock_ratio_select_pins = 2'h0;
        refresh_cnt = 0;
    end
    // refresh follows rate.
    // Counting interface cycles, not time, keeps refresh correct at 1/4 rate.
    always @(posedge system_interface_clock) refresh_cnt <= refresh_cnt + 1;
    task automatic power_on(input int n);
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (n) @(posedge ref_clk);
        rst <= 1'b0;
    endtask
    task automatic warm(input int n);
        @(posedge ref_clk);
        warm_reset_n <= 1'b0;
        repeat (n) @(posedge ref_clk);
        warm_reset_n <= 1'b1;
    endtask
    task automatic set_ratio(input logic [1:0] r);
        @(posedge ref_clk);
        clock_ratio_select_pins <= r;
    endtask
endmodule

// [sim/crc_top_tb_top.sv]
// Self-checking bench for the clock ratio and reset block.
`timescale 1ns/1ps
module crc_top_tb_top;
    logic ref_clk, rst, warm_reset_n;
    logic [1:0] pins;
    logic [11:0] paddr;
    logic psel, penable, pwrite, pready, pslverr;
    logic [31:0] pwdata, prdata;
    logic pipeline_clock, system_interface_clock, transmit_clock;
    logic pipeline_reset, system_reset, endian_select, write_slot;
    int n_fail;
    int samples_checked;
    localparam logic [31:0] CFG_DEF = 32'h01040000;
    localparam int PIPE_RISES [4] = '{4, 8, 12, 6};

    crc_board_model board (.ref_clk(ref_clk),
        .system_interface_clock(system_interface_clock), .rst(rst),
        .warm_reset_n(warm_reset_n), .clock_ratio_select_pins(pins));
    crc_top uut (.ref_clk(ref_clk), .rst(rst),
        .warm_reset_n(warm_reset_n), .clock_ratio_select_pins(pins),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pipeline_clock(pipeline_clock),
        .system_interface_clock(system_interface_clock),
        .transmit_clock(transmit_clock), .pipeline_reset(pipeline_reset),
        .system_reset(system_reset), .endian_select(endian_select),
        .write_slot(write_slot));

    task automatic complete_run();
        $display("checked %0d failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic bad(input string m);
        n_fail++;
        $display("BAD t=%0t %s", $time, m);
    endtask
    task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) bad($sformatf("word %h want %h", g, e));
    endtask
    task automatic chk_bit(input logic g, input logic e);
        samples_checked++;
        if (g !== e) bad($sformatf("bit %b want %b", g, e));
    endtask
    task automatic chk_num(input int g, input int e);
        samples_checked++;
        if (g != e) bad($sformatf("count %0d want %0d", g, e));
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d, output logic [31:0] q, output logic e);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1);
        if (pready !== 1'b1) bad("no pready");
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    function automatic logic pick(input int i);
        case (i)
            0: return pipeline_clock;
            1: return system_interface_clock;
            2: return transmit_clock;
            default: return write_slot;
        endcase
    endfunction
    task automatic sync_sys();
        logic p;
        int n;
        p = 1'b1;
        n = 0;
        while (!(p === 1'b0 && system_interface_clock === 1'b1) && n < 200)
        begin
            p = system_interface_clock;
            @(negedge ref_clk);
            n++;
        end
        if (n >= 200) bad("system clock never rose");
    endtask
    task automatic rises(input int w, output int c[4]);
        logic p[4];
        for (int i = 0; i < 4; i++) begin
            p[i] = pick(i);
            c[i] = 0;
        end
        repeat (w) begin
            @(negedge ref_clk);
            chk_bit(transmit_clock, system_interface_clock);
            for (int i = 0; i < 4; i++) begin
                if (p[i] === 1'b0 && pick(i) === 1'b1) c[i]++;
                p[i] = pick(i);
            end
        end
    endtask
    task automatic wait_rel(output int n);
        n = 0;
        while (pipeline_reset !== 1'b0 && n < 40) begin
            @(negedge ref_clk);
            n++;
        end
    endtask
    task automatic test_regs();
        logic [31:0] q;
        logic e;
        apb(1'b0, 12'h000, 32'h0, q, e);
        chk_word(q, CFG_DEF);
        wr(12'h000, 32'hfefffffe);
        apb(1'b0, 12'h000, 32'h0, q, e);
        chk_word(q, 32'h00048000);
        chk_bit(endian_select, 1'b1);
        apb(1'b0, 12'h008, 32'h0, q, e);
        chk_bit(e, 1'b1);
        chk_word(q, 32'h0);
        apb(1'b1, 12'h004, 32'hffffffff, q, e);
        chk_bit(e, 1'b0);
        apb(1'b0, 12'h000, 32'h0, q, e);
        chk_word(q, 32'h00048000);
        $display("register test done");
    endtask
    task automatic test_slot();
        int c[4];
        wr(12'h000, 32'h0);
        repeat (40) @(posedge ref_clk);
        sync_sys();
        rises(72, c);
        chk_num(c[3], 12);
        wr(12'h000, 32'h01000000);
        repeat (40) @(posedge ref_clk);
        sync_sys();
        rises(72, c);
        chk_num(c[3], 4);
        $display("write slot test done");
    endtask
    task automatic test_ratio(input logic slow);
        int c[4];
        int r0;
        logic [31:0] q;
        logic e;
        wr(12'h000, {31'h0, slow});
        for (int r = 0; r < 4; r++) begin
            board.set_ratio(r[1:0]);
            repeat (120) @(posedge ref_clk);
            apb(1'b0, 12'h004, 32'h0, q, e);
            chk_word(q & 32'h7, {29'h0, slow, r[1:0]});
            sync_sys();
            r0 = board.refresh_cnt;
            rises(slow ? 96 : 24, c);
            chk_num(c[1], 4);
            chk_num(c[0], PIPE_RISES[r]);
            chk_num(board.refresh_cnt - r0, 4);
        end
        $display("ratio test done slow=%0d", slow);
    endtask
    task automatic test_warm();
        int n;
        int c[4];
        logic [31:0] q;
        logic e;
        wr(12'h000, 32'h00008000);
        repeat (60) @(posedge ref_clk);
        fork
            board.warm(12);
            begin
                repeat (5) @(negedge ref_clk);
                chk_bit(pipeline_reset, 1'b1);
                chk_bit(system_reset, 1'b1);
                rises(6, c);
                chk_num(c[1], 1);
            end
        join
        wait_rel(n);
        chk_bit(system_reset, 1'b0);
        apb(1'b0, 12'h000, 32'h0, q, e);
        chk_word(q, 32'h00048000);
        $display("warm reset test done");
    endtask
    task automatic test_por();
        int n;
        logic [31:0] q;
        logic e;
        board.power_on(3);
        @(negedge ref_clk);
        chk_bit(endian_select, 1'b0);
        chk_bit(pipeline_clock, 1'b0);
        chk_bit(pipeline_reset, 1'b1);
        wait_rel(n);
        chk_bit(n < 12, 1'b1);
        chk_bit(system_reset, 1'b0);
        apb(1'b0, 12'h000, 32'h0, q, e);
        chk_word(q, CFG_DEF);
        $display("power-on reset test done");
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    initial begin
        #160000;
        bad("watchdog expired");
        complete_run();
    end
    initial begin
        int n;
        n_fail = 0;
        samples_checked = 0;
        paddr = 12'h0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h0;
        board.power_on(6);
        wait_rel(n);
        chk_bit(pipeline_reset, 1'b0);
        test_regs();
        test_slot();
        test_ratio(1'b0);
        test_ratio(1'b1);
        test_warm();
        test_por();
        complete_run();
    end
endmodule
